//--- logic/sst_pkg.sv
package sst_pkg;

  // Clock and control cycle
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CTRL_PERIOD_US = 1000;
  localparam int unsigned CTRL_CYCLES    = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;

  // Word indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL    = 6'h00;
  localparam logic [5:0] IDX_SPD_OUT = 6'h01;
  localparam logic [5:0] IDX_TRQ_OUT = 6'h02;
  localparam logic [5:0] IDX_TRQ_LIM = 6'h03;
  localparam logic [5:0] IDX_JOG     = 6'h15;
  localparam logic [5:0] IDX_SRC     = 6'h17;
  localparam logic [5:0] IDX_PRESET1 = 6'h18;
  localparam logic [5:0] IDX_REACH   = 6'h1c;
  localparam logic [5:0] IDX_TGAIN   = 6'h1d;
  localparam logic [5:0] IDX_TDIR    = 6'h1e;
  localparam logic [5:0] IDX_TOFS    = 6'h1f;
  localparam logic [5:0] IDX_TMCAP   = 6'h20;
  localparam logic [5:0] IDX_DO_STAT = 6'h21;
  localparam logic [5:0] IDX_DI_STAT = 6'h22;
  localparam logic [5:0] IDX_MCAP    = 6'h23;
  localparam logic [5:0] IDX_TCAP    = 6'h24;
  localparam logic [5:0] IDX_NEGSP   = 6'h25;
  localparam logic [5:0] IDX_POSSP   = 6'h26;
  localparam logic [5:0] IDX_FLOOR   = 6'h27;
  localparam logic [5:0] IDX_ACC     = 6'h28;
  localparam logic [5:0] IDX_DEC     = 6'h29;
  localparam logic [5:0] IDX_SCRV    = 6'h2a;
  localparam logic [5:0] IDX_SGAIN   = 6'h2b;
  localparam logic [5:0] IDX_SDIR    = 6'h2c;

  // Control modes
  localparam logic [2:0] MODE_POSITION = 3'h0;
  localparam logic [2:0] MODE_SPEED    = 3'h1;
  localparam logic [2:0] MODE_TORQUE   = 3'h2;
  localparam logic [2:0] MODE_INTERNAL = 3'h3;
  localparam logic [2:0] MODE_JOG      = 3'h4;

  // Speed sources
  localparam logic [2:0] SRC_ANALOG    = 3'h0;
  localparam logic [2:0] SRC_TERMINALS = 3'h5;

  // Scaling constants
  localparam int OFS_LIMIT    = 2000;
  localparam int MV_PER_VOLT  = 1000;
  localparam int RAMP_SPAN    = 1000;
  localparam int FRAC_BITS    = 16;
  localparam int SETTLE_BAND  = 1;

  function automatic logic is_param(input logic [5:0] idx);
    return (idx == IDX_CTRL) || (idx == IDX_JOG) ||
           ((idx >= IDX_SRC) && (idx <= IDX_TMCAP)) ||
           ((idx >= IDX_MCAP) && (idx <= IDX_SDIR));
  endfunction : is_param

  function automatic logic [15:0] reset_word(input logic [5:0] idx);
    case (idx)
      IDX_CTRL:  return 16'h0001;
      IDX_TGAIN: return 16'h001e;
      IDX_TMCAP: return 16'h0e10;
      IDX_MCAP:  return 16'h0e10;
      IDX_TCAP:  return 16'h012c;
      IDX_NEGSP: return 16'h0064;
      IDX_POSSP: return 16'h0064;
      IDX_SGAIN: return 16'h012c;
      default:   return 16'h0000;
    endcase
  endfunction : reset_word

endpackage : sst_pkg

//--- logic/sst_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sst_mem_if;
  logic              we;
  logic [1:0]        be;
  logic [5:0]        waddr;
  logic [15:0]       wdata;
  logic [5:0]        raddr;
  logic [15:0]       rdata;
  logic [63:0][15:0] words;

  modport ctrl (output we, be, waddr, wdata, raddr, input rdata, words);
  modport mem  (input we, be, waddr, wdata, raddr, output rdata, words);
endinterface : sst_mem_if
`default_nettype wire

//--- logic/sst_param_mem.sv
`timescale 1ns/100ps
`default_nettype none
module sst_param_mem
  import sst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access port
  sst_mem_if.mem   m
);

  typedef struct packed {
    logic [63:0][15:0] words;
    logic [15:0]       rdata;
  } sst_mem_s;

  sst_mem_s st_q;
  sst_mem_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.rdata = st_q.words[m.raddr];
    if (m.we && m.be[0]) begin
      st_d.words[m.waddr][7:0] = m.wdata[7:0];
    end
    if (m.we && m.be[1]) begin
      st_d.words[m.waddr][15:8] = m.wdata[15:8];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        st_q.words[i] <= reset_word(6'(i));
      end
      st_q.rdata <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign m.rdata = st_q.rdata;
  assign m.words = st_q.words;

endmodule : sst_param_mem
`default_nettype wire

//--- logic/sst_command.sv
`timescale 1ns/100ps
`default_nettype none
module sst_command
  import sst_pkg::*;
#(
  parameter int unsigned CYCLES_PER_TICK = CTRL_CYCLES
)
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // Wishbone slave
  input  wire logic [31:0] WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Analog inputs, digitized in mV
  input  wire logic [15:0] SPEED_VOLT_MV,
  input  wire logic [15:0] TORQUE_VOLT_MV,
  // Feedback from the motor loop
  input  wire logic [15:0] FEEDBACK_SPEED,
  input  wire logic [15:0] FEEDBACK_TORQUE,
  // Terminals
  input  wire logic [3:0]  INPUT_TERMINALS,
  output logic      [2:0]  OUTPUT_TERMINALS,
  // Commands to the motor loop
  output logic      [15:0] SPEED_CMD,
  output logic      [15:0] TORQUE_CMD,
  output logic      [15:0] TORQUE_LIMIT,
  output logic             CMD_STROBE
);

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_READ = 3'b010,
    BUS_ACK  = 3'b100
  } sst_bus_e;

  typedef struct packed {
    sst_bus_e    bus;
    logic [5:0]  adr;
    logic        hit;
    logic        ack;
    logic [31:0] dat;
    logic [15:0] cnt;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [31:0] tgt;
    logic [31:0] ramp;
    logic [31:0] scrv;
    logic [15:0] trq;
    logic [15:0] tlim;
    logic [2:0]  dout;
    logic        strobe;
  } sst_state_s;

  sst_state_s st_q;
  sst_state_s st_d;

  sst_mem_if mem_if ();

  sst_param_mem u_mem (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .m   (mem_if.mem)
  );

  function automatic int sx(input logic [15:0] v);
    return int'($signed(v));
  endfunction : sx

  function automatic int clampi(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampi

  function automatic int absi(input int v);
    return (v < 0) ? -v : v;
  endfunction : absi

  function automatic int par(input logic [5:0] idx);
    return sx(mem_if.words[idx]);
  endfunction : par

  // Bus writes land in the parameter store on the request's first edge
  assign mem_if.we    = (st_q.bus == BUS_IDLE) && WB_CYC_I && WB_STB_I && WB_WE_I &&
                        (WB_ADR_I[31:8] == 24'h000000) && is_param(WB_ADR_I[7:2]);
  assign mem_if.be    = WB_SEL_I[1:0];
  assign mem_if.waddr = WB_ADR_I[7:2];
  assign mem_if.wdata = WB_DAT_I[15:0];
  assign mem_if.raddr = WB_ADR_I[7:2];

  always_comb begin
    logic [2:0] mode;
    logic [2:0] src;
    logic [1:0] pick;
    logic       tick;
    int         rpm;
    int         cap;
    int         trq;
    int         tlim;
    int         gain;
    int         diff;
    int         step;
    int         fb;
    int         rtime;
    int         scv;
    mode  = mem_if.words[IDX_CTRL][2:0];
    src   = mem_if.words[IDX_SRC][2:0];
    pick  = 2'h0;
    tick  = (st_q.cnt == 16'(CYCLES_PER_TICK - 1));
    rpm   = 0;
    cap   = 0;
    trq   = 0;
    tlim  = 0;
    gain  = 0;
    diff  = 0;
    step  = 0;
    fb    = 0;
    rtime = 0;
    scv   = 0;
    st_d  = st_q;

    // Pins cross into the clock domain through two flops
    st_d.sync1 = INPUT_TERMINALS;
    st_d.sync2 = st_q.sync1;

    // Bus slave: ack two edges after the request is seen
    st_d.ack = 1'b0;
    case (st_q.bus)
      BUS_IDLE: begin
        if (WB_CYC_I && WB_STB_I) begin
          st_d.adr = WB_ADR_I[7:2];
          st_d.hit = (WB_ADR_I[31:8] == 24'h000000);
          st_d.bus = BUS_READ;
        end
      end
      BUS_READ: begin
        st_d.dat = 32'h00000000;
        if (st_q.hit) begin
          case (st_q.adr)
            IDX_SPD_OUT: st_d.dat = {{16{st_q.scrv[31]}}, st_q.scrv[31:16]};
            IDX_TRQ_OUT: st_d.dat = {{16{st_q.trq[15]}}, st_q.trq};
            IDX_TRQ_LIM: st_d.dat = {16'h0000, st_q.tlim};
            IDX_DO_STAT: st_d.dat = {29'h0000000, st_q.dout};
            IDX_DI_STAT: st_d.dat = {28'h0000000, st_q.sync2};
            default: begin
              if (is_param(st_q.adr)) begin
                st_d.dat = {{16{mem_if.rdata[15]}}, mem_if.rdata};
              end
            end
          endcase
        end
        st_d.ack = 1'b1;
        st_d.bus = BUS_ACK;
      end
      BUS_ACK: begin
        st_d.bus = BUS_IDLE;
      end
      default: begin
        st_d.bus = BUS_IDLE;
      end
    endcase

    // Control-cycle divider
    st_d.cnt    = tick ? 16'h0000 : st_q.cnt + 16'h0001;
    st_d.strobe = tick;

    // Stage 1: source selection, scaling and limits
    if (src == SRC_TERMINALS || mode == MODE_INTERNAL) begin
      pick = st_q.sync2[2:1];
    end else if (src != SRC_ANALOG) begin
      pick = 2'(src - 3'h1);
    end
    case (mode)
      MODE_SPEED, MODE_INTERNAL: begin
        if (mode == MODE_SPEED && src == SRC_ANALOG) begin
          rpm = sx(SPEED_VOLT_MV) * par(IDX_SGAIN) / MV_PER_VOLT;
          if (mem_if.words[IDX_SDIR][0]) begin
            rpm = -rpm;
          end
          if (rpm != 0 && absi(rpm) < par(IDX_FLOOR)) begin
            rpm = (rpm < 0) ? -par(IDX_FLOOR) : par(IDX_FLOOR);
          end
        end else if (src <= 3'h5) begin
          rpm = par(IDX_PRESET1 + 6'(pick));
        end
      end
      MODE_JOG:    rpm = par(IDX_JOG);
      MODE_TORQUE: rpm = par(IDX_TMCAP);
      default:     rpm = 0;
    endcase
    cap = par(IDX_MCAP);
    if (mode == MODE_TORQUE && par(IDX_TMCAP) < cap) begin
      cap = par(IDX_TMCAP);
    end
    rpm = clampi(rpm, -cap, cap);

    if (mode == MODE_INTERNAL || mode == MODE_JOG) begin
      tlim = par(IDX_POSSP);
    end else begin
      tlim = par(IDX_TCAP);
    end
    gain = par(IDX_TGAIN);
    if (mode == MODE_TORQUE && gain > 0) begin
      trq = (sx(TORQUE_VOLT_MV) + clampi(par(IDX_TOFS), -OFS_LIMIT, OFS_LIMIT))
            / gain;
      if (mem_if.words[IDX_TDIR][0]) begin
        trq = -trq;
      end
    end
    trq = clampi(trq, -tlim, tlim);

    // Stage 2 reads last cycle's target and stage 3 last cycle's ramp, giving a fixed pipeline
    if (tick) begin
      st_d.tgt  = 32'(rpm * (2 ** FRAC_BITS));
      st_d.trq  = 16'(trq);
      st_d.tlim = 16'(tlim);
      diff = int'($signed(st_q.tgt)) - int'($signed(st_q.ramp));
      if (mode == MODE_SPEED) begin
        if (absi(int'($signed(st_q.tgt))) > absi(int'($signed(st_q.ramp)))) begin
          rtime = par(IDX_ACC);
        end else begin
          rtime = par(IDX_DEC);
        end
      end
      if (rtime > 0) begin
        step = RAMP_SPAN * (2 ** FRAC_BITS) / rtime;
        diff = clampi(diff, -step, step);
      end
      st_d.ramp = 32'(int'($signed(st_q.ramp)) + diff);
      // First-order stage after the linear ramp rounds its corners
      scv = par(IDX_SCRV);
      diff = int'($signed(st_q.ramp)) - int'($signed(st_q.scrv));
      if (scv > 0) begin
        diff = diff / scv;
        if (diff == 0 && st_q.ramp != st_q.scrv) begin
          diff = (st_q.ramp > st_q.scrv) ? 1 : -1;
        end
      end
      st_d.scrv = 32'(int'($signed(st_q.scrv)) + diff);
    end

    // Output terminals, refreshed every clock
    fb = sx(FEEDBACK_SPEED);
    st_d.dout[0] = (mode != MODE_POSITION) && (absi(fb) > par(IDX_REACH));
    fb = sx(FEEDBACK_TORQUE);
    st_d.dout[1] = (fb >= par(IDX_POSSP)) ||
                   (fb <= -par(IDX_NEGSP));
    st_d.dout[2] = absi(int'($signed(st_q.tgt[31:16])) -
                        int'($signed(st_q.scrv[31:16]))) <= SETTLE_BAND;
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= '{bus: BUS_IDLE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign WB_DAT_O         = st_q.dat;
  assign WB_ACK_O         = st_q.ack;
  assign OUTPUT_TERMINALS = st_q.dout;
  assign SPEED_CMD        = st_q.scrv[31:16];
  assign TORQUE_CMD       = st_q.trq;
  assign TORQUE_LIMIT     = st_q.tlim;
  assign CMD_STROBE       = st_q.strobe;

endmodule : sst_command
`default_nettype wire

//--- verification/sst_command_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sst_command_chk
  import sst_pkg::*;
#(
  parameter int unsigned CYCLES_PER_TICK = CTRL_CYCLES,
  parameter int          POS_SETPOINT    = 100,
  parameter int          NEG_SETPOINT    = 100
)
(
  // Clock, reset and bus handshake
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  // Motor loop side
  input wire logic [15:0] FEEDBACK_TORQUE,
  input wire logic [2:0]  OUTPUT_TERMINALS,
  input wire logic [15:0] SPEED_CMD,
  input wire logic [15:0] TORQUE_LIMIT,
  input wire logic        CMD_STROBE
);
  // Set points are assumed at their defaults; a bench that rewrites them must pass new values
  int unsigned gap_q;
  int unsigned gap_d;
  logic        seen_q;

  always_comb begin
    gap_d = CMD_STROBE ? 0 : gap_q + 1;
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gap_q  <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_q | CMD_STROBE;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_delay: assert property ($rose(WB_CYC_I && WB_STB_I) |-> ##[1:2] WB_ACK_O)
    else $error("bus request not acknowledged in time");
  a_trq_pos: assert property ($signed(FEEDBACK_TORQUE) >= POS_SETPOINT
    |=> OUTPUT_TERMINALS[1]) else $error("positive torque reached flag missing");
  a_trq_neg: assert property ($signed(FEEDBACK_TORQUE) <= -NEG_SETPOINT
    |=> OUTPUT_TERMINALS[1]) else $error("negative torque reached flag missing");
  a_trq_band: assert property ($signed(FEEDBACK_TORQUE) < POS_SETPOINT &&
    $signed(FEEDBACK_TORQUE) > -NEG_SETPOINT |=> !OUTPUT_TERMINALS[1])
    else $error("torque reached flag inside band");
  a_speed_cap: assert property ($signed(SPEED_CMD) <= 3600 &&
    $signed(SPEED_CMD) >= -3600) else $error("speed command beyond cap");
  a_tlim_cap: assert property (TORQUE_LIMIT <= 800)
    else $error("torque limit beyond range");
  a_strobe_pulse: assert property (CMD_STROBE |=> !CMD_STROBE)
    else $error("strobe longer than one cycle");
  a_strobe_gap: assert property (CMD_STROBE && seen_q |-> gap_q == CYCLES_PER_TICK - 1)
    else $error("strobe spacing wrong");
endmodule : sst_command_chk

bind sst_command sst_command_chk #(
  .CYCLES_PER_TICK(CYCLES_PER_TICK)
) sst_command_chk_inst (
  .CORE_CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .FEEDBACK_TORQUE,
  .OUTPUT_TERMINALS, .SPEED_CMD, .TORQUE_LIMIT, .CMD_STROBE
);
`default_nettype wire

//--- verification/sst_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sst_host_model (
  // Clock
  input  wire logic        clk,
  // Analog levels in mV and terminal pins
  output logic      [15:0] speed_mv,
  output logic      [15:0] torque_mv,
  output logic      [3:0]  pins
);
  initial begin
    speed_mv  = '0;
    torque_mv = '0;
    pins      = '0;
  end

  // Called right after an edge; pins change on the next clock edge, but the design must still synchronise them
  task automatic drive(input logic [15:0] s, input logic [15:0] t, input logic [3:0] p);
    @(posedge clk);
    speed_mv  <= s;
    torque_mv <= t;
    pins      <= p;
  endtask : drive
endmodule : sst_host_model
`default_nettype wire

//--- verification/test_sst_command.sv
`timescale 1ns/100ps
`default_nettype none
module test_sst_command
  import sst_pkg::*;
;
  localparam int TICK = 20;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [31:0] adr      = '0;
  logic [31:0] wdat     = '0;
  logic [15:0] fb_spd   = '0;
  logic [15:0] fb_trq   = '0;
  logic [31:0] rdat;
  logic        ack;
  logic [15:0] s_mv;
  logic [15:0] t_mv;
  logic [3:0]  pins;
  logic [2:0]  dout;
  logic [15:0] spd_cmd;
  logic [15:0] trq_cmd;
  logic [15:0] tlim_o;
  logic [31:0] v;
  int          err_total   = 0;
  int          comparisons = 0;
  int          cyc_cnt     = 0;
  int          k;
  int          d;
  int          prev;
  logic [5:0]  ri [9] = '{IDX_CTRL, IDX_TGAIN, IDX_TMCAP, IDX_MCAP, IDX_TCAP, IDX_NEGSP,
                          IDX_POSSP, IDX_SGAIN, IDX_FLOOR};
  int rv [9]    = '{1, 30, 3600, 3600, 300, 100, 100, 300, 0};
  int pv [4]    = '{100, -200, 300, -3600};
  int an [5][5] = '{'{0, 0, 3600, 5000, 1500}, '{1, 0, 3600, 5000, -1500},
    '{0, 1000, 3600, 1000, 1000}, '{0, 0, 800, 5000, 800}, '{0, 0, 3600, -2000, -600}};
  int tq [5][4] = '{'{0, 0, 3000, 100}, '{1, 0, 3000, -100}, '{0, 300, 3000, 110},
    '{0, 5000, 3000, 166}, '{0, -5000, 3000, 33}};
  int lm [3][2] = '{'{1, 250}, '{3, 100}, '{4, 100}};
  int st [4][4] = '{'{1, 501, 150, 3}, '{1, 500, 99, 0}, '{1, -600, -100, 3}, '{0, 900, -99, 0}};
  int rp [3][4] = '{'{100, 0, 0, 1000}, '{0, 50, 0, 0}, '{0, 0, 10, 500}};

  always #25 core_clk = ~core_clk;

  sst_host_model sst_host_model_inst (
    .clk       (core_clk),
    .speed_mv  (s_mv),
    .torque_mv (t_mv),
    .pins      (pins)
  );

  sst_command #(.CYCLES_PER_TICK(TICK)) sst_command_inst (
    .CORE_CLK (core_clk), .SYS_RST (sys_rst), .WB_ADR_I (adr), .WB_DAT_I (wdat),
    .WB_SEL_I (4'hf), .WB_WE_I (we), .WB_CYC_I (cyc), .WB_STB_I (stb),
    .WB_DAT_O (rdat), .WB_ACK_O (ack), .SPEED_VOLT_MV (s_mv), .TORQUE_VOLT_MV (t_mv),
    .FEEDBACK_SPEED (fb_spd), .FEEDBACK_TORQUE (fb_trq), .INPUT_TERMINALS (pins),
    .OUTPUT_TERMINALS (dout), .SPEED_CMD (spd_cmd), .TORQUE_CMD (trq_cmd),
    .TORQUE_LIMIT (tlim_o),
    .CMD_STROBE ()
  );

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= dt;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    v = rdat;
    if (n >= 100) err_total++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  task automatic wr(input logic [5:0] i, input logic [15:0] x);
    wb(1'b1, {24'h0, i, 2'h0}, {16'h0, x});
  endtask : wr

  task automatic rd(input logic [5:0] i);
    wb(1'b0, {24'h0, i, 2'h0}, '0);
  endtask : rd

  task automatic tk(input int n);
    repeat (n * TICK) @(posedge core_clk);
  endtask : tk

  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Run is about 15000 cycles; the ceiling leaves room without letting a hang drag on
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt > 40000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 9; k++) begin
      rd(ri[k]);
      check("reset value", v, rv[k]);
    end
    for (k = 0; k < 4; k++) wr(6'(IDX_PRESET1 + k), 16'(pv[k]));
    for (k = 1; k < 9; k++) begin
      wr(IDX_SRC, (k < 5) ? 16'(k) : 16'h5);
      sst_host_model_inst.drive(16'h0, 16'h0, (k < 5) ? 4'h0 : {1'b0, 2'(k - 5), 1'b0});
      tk(5);
      rd(IDX_SPD_OUT);
      check("preset speed", v, pv[(k < 5) ? k - 1 : k - 5]);
    end
    wr(IDX_SRC, 16'h0);
    for (k = 0; k < 5; k++) begin
      wr(IDX_SDIR, 16'(an[k][0]));
      wr(IDX_FLOOR, 16'(an[k][1]));
      wr(IDX_MCAP, 16'(an[k][2]));
      sst_host_model_inst.drive(16'(an[k][3]), 16'h0, 4'h0);
      tk(5);
      rd(IDX_SPD_OUT);
      check("analog speed", v, an[k][4]);
    end
    wr(IDX_CTRL, 16'h2);
    wr(IDX_TMCAP, 16'd500);
    for (k = 0; k < 5; k++) begin
      wr(IDX_TDIR, 16'(tq[k][0]));
      wr(IDX_TOFS, 16'(tq[k][1]));
      sst_host_model_inst.drive(16'h0, 16'(tq[k][2]), 4'h0);
      tk(5);
      rd(IDX_TRQ_OUT);
      check("torque command", v, tq[k][3]);
      check("torque port", {{16{trq_cmd[15]}}, trq_cmd}, tq[k][3]);
    end
    rd(IDX_SPD_OUT);
    check("torque mode speed", v, 500);
    wr(IDX_TCAP, 16'd250);
    for (k = 0; k < 3; k++) begin
      wr(IDX_CTRL, 16'(lm[k][0]));
      tk(3);
      rd(IDX_TRQ_LIM);
      check("torque limit", v, lm[k][1]);
      check("limit port", {16'h0, tlim_o}, lm[k][1]);
    end
    wr(IDX_REACH, 16'd500);
    for (k = 0; k < 4; k++) begin
      wr(IDX_CTRL, 16'(st[k][0]));
      fb_spd <= 16'(st[k][1]);
      fb_trq <= 16'(st[k][2]);
      tk(1);
      rd(IDX_DO_STAT);
      check("output status", v & 32'h3, st[k][3]);
      check("output pins", {30'h0, dout[1:0]}, st[k][3]);
    end
    for (k = 6; k < 10; k += 3) begin
      sst_host_model_inst.drive(16'h0, 16'h0, 4'(k));
      tk(1);
      rd(IDX_DI_STAT);
      check("input status", v, k);
    end
    wr(IDX_CTRL, 16'h1);
    wr(IDX_SRC, 16'h1);
    wr(IDX_PRESET1, 16'h0);
    sst_host_model_inst.drive(16'h0, 16'h0, 4'h0);
    tk(5);
    prev = 0;
    for (k = 0; k < 3; k++) begin
      wr(IDX_ACC, 16'(rp[k][0]));
      wr(IDX_DEC, 16'(rp[k][1]));
      wr(IDX_SCRV, 16'(rp[k][2]));
      wr(IDX_PRESET1, 16'(rp[k][3]));
      tk(6);
      rd(IDX_SPD_OUT);
      d = $signed(v);
      check("ramp midway", 32'((d - prev) * (rp[k][3] - prev) > 0 && d != rp[k][3]), 1);
      check("settled midway", {31'h0, dout[2]}, 0);
      // The smoothing stage creeps its last fraction bits one per tick, so give it time to land
      tk(200);
      rd(IDX_SPD_OUT);
      check("ramp end", v, rp[k][3]);
      check("speed port", {{16{spd_cmd[15]}}, spd_cmd}, rp[k][3]);
      check("settled pin", {31'h0, dout[2]}, 1);
      prev = rp[k][3];
    end
    wr(IDX_SPD_OUT, 16'h0123);
    rd(IDX_SPD_OUT);
    check("read-only write", v, 500);
    wb(1'b1, 32'h100, 32'h4);
    wb(1'b0, 32'h100, '0);
    check("unmapped read", v, 0);
    rd(IDX_CTRL);
    check("unmapped write", v, 1);
    print_verdict();
  end
endmodule : test_sst_command
`default_nettype wire
